// ===== logic/wwdt_consts.svh
// Constants for the windowed watchdog: offsets, field positions, reset values, timing counts
`ifndef WWDT_CONSTS_SVH
`define WWDT_CONSTS_SVH

// Register offsets on the plain register port
`define WWDT_OFS_CONTROL 8'h00
`define WWDT_OFS_STATUS 8'h01
`define WWDT_OFS_GUARD 8'h02

// Field positions
`define WWDT_CTRL_PERIOD_LSB 0
`define WWDT_CTRL_WINDOW_LSB 4
`define WWDT_STAT_LOCK_BIT 7
`define WWDT_STAT_SYNC_BIT 0

// Reset values of plain fields
`define WWDT_RDATA_RST 8'h00
`define WWDT_GUARD_RST 4'h0

// Timing counts
`define WWDT_CODE_OFF 4'h0
`define WWDT_CODE_MAX 4'hB
`define WWDT_BASE_CYCLES 14'h0008
`define WWDT_SYNC_LAST 2'h1
`define WWDT_GUARD_INSTR 4'h4
`define WWDT_UNLOCK_KEY 8'hA5

`endif

// ===== logic/wwdt_pkg.sv
// Types shared by the windowed watchdog design
`default_nettype none

package wwdt_pkg;

   // Position of the watchdog count within its sequence
   typedef enum logic [1:0] {
      WWDT_IDLE,
      WWDT_FIRST,
      WWDT_CLOSED,
      WWDT_OPEN
   } wwdt_phase_t;

   // One request on the register port
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } wwdt_bus_req_t;

   // Whole state of the block
   typedef struct packed {
      logic [7:0] ctrl;
      logic [3:0] run_period;
      logic [3:0] run_window;
      logic lock;
      logic sync_pend;
      logic [1:0] sync_cnt;
      logic rst_pend;
      logic [1:0] rst_cnt;
      logic [3:0] guard_cnt;
      logic [13:0] cnt;
      wwdt_phase_t phase;
      logic wd_prev;
      logic dbg_prev;
      logic sys_reset;
      logic [7:0] rdata;
   } wwdt_state_t;

endpackage : wwdt_pkg

`default_nettype wire

// ===== logic/wwdt_top.sv
// Windowed watchdog timer with keyed configuration, lock and restart synchroniser
// Function
// - Watchdog runs only while the period field is non-zero.
// - Normal mode resets the system when no restart arrives before timeout.
// - Each accepted restart outside the closed period clears the count and starts a fresh period.
// - Eleven timeout lengths from about eight milliseconds to about eight seconds.
// - Period and window codes 1..11 give 8 doubling to 8K watchdog clocks.
// - Window field zero selects normal mode, non-zero selects window mode.
// - Restart during the closed period resets the system at once.
// - Open period follows closed period; timeout in it resets the system.
// - After enabling window mode or debug, closed period waits for first restart.
// - A restart needs one to two watchdog clocks before it acts.
// - A restart arriving while one is still synchronising is ignored.
// - While locked, period and window fields cannot change.
// - Software can only set the lock; it clears only in debug.
// - Control loads from fuses at reset; enabled fuse config sets the lock.
// - Control writes cross to the watchdog clock, flagged by a busy bit.
// - Busy flag sets on control write and clears when transfer completes.
// - Protected writes work only within four cycles after the unlock key.
// - Protected bits stay unchanged when written without a valid unlock.
// - Watchdog keeps counting in active and sleep modes while clock runs.
// - Debug halt stops the watchdog and clears its counter.
// - Leaving debug in window mode runs a normal timeout first.
// - Counter advances on the 1 kHz watchdog oscillator clock.
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "wwdt_consts.svh"
`default_nettype none

module wwdt_top #(
   parameter logic [3:0] GUARD_CYCLES = `WWDT_GUARD_INSTR,
   parameter logic [7:0] UNLOCK_KEY = `WWDT_UNLOCK_KEY // Arbitrary value
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire wwdt_pkg::wwdt_bus_req_t bus_req,
   output logic [7:0] rdata,
   input wire logic watchdog_restart_instr,
   input wire logic debug_halt,
   input wire logic wd_osc_clk,
   input wire logic [7:0] wd_fuse_config,
   output logic wd_sys_reset
);

   // ************************************************************
   // Helper functions
   // ************************************************************

   // Timeout length in watchdog clocks; reserved codes clamp to the longest
   function automatic logic [13:0] wwdt_cycles(input logic [3:0] code);
      logic [3:0] c;
      c = (code > `WWDT_CODE_MAX) ? `WWDT_CODE_MAX : code;
      if (c == `WWDT_CODE_OFF)
      begin
         c = 4'h1;
      end
      wwdt_cycles = `WWDT_BASE_CYCLES << (c - 4'h1);
   endfunction : wwdt_cycles

   // Phase to enter when a configuration becomes active
   function automatic wwdt_pkg::wwdt_phase_t wwdt_start_phase(input logic [7:0] cfg);
      if (cfg[`WWDT_CTRL_PERIOD_LSB +: 4] == `WWDT_CODE_OFF)
      begin
         wwdt_start_phase = wwdt_pkg::WWDT_IDLE;
      end
      else if (cfg[`WWDT_CTRL_WINDOW_LSB +: 4] != `WWDT_CODE_OFF)
      begin
         wwdt_start_phase = wwdt_pkg::WWDT_FIRST;
      end
      else
      begin
         wwdt_start_phase = wwdt_pkg::WWDT_OPEN;
      end
   endfunction : wwdt_start_phase

   // Register read decode; unmapped offsets read zero
   function automatic logic [7:0] wwdt_read(input logic [7:0] addr,
                                            input wwdt_pkg::wwdt_state_t s);
      logic [7:0] v;
      v = 8'h00;
      if (addr == `WWDT_OFS_CONTROL)
      begin
         v = s.ctrl;
      end
      else if (addr == `WWDT_OFS_STATUS)
      begin
         v[`WWDT_STAT_LOCK_BIT] = s.lock;
         v[`WWDT_STAT_SYNC_BIT] = s.sync_pend;
      end
      wwdt_read = v;
   endfunction : wwdt_read

   // ************************************************************
   // State and event decode
   // ************************************************************

   wwdt_pkg::wwdt_state_t s_q;
   wwdt_pkg::wwdt_state_t s_d;
   logic tick;
   logic cfg_fire;
   logic restart_fire;
   logic debug_exit;
   logic run_tick;
   logic guard_open;
   logic ctrl_write_ok;
   logic [13:0] limit;
   logic [13:0] cnt_inc;

   // Oscillator edge seen as a one-cycle tick of the system clock
   assign tick = ce & wd_osc_clk & ~s_q.wd_prev;
   // Transfers complete on the second tick after they start: 1 to 2 osc periods
   assign cfg_fire = tick & s_q.sync_pend & (s_q.sync_cnt == `WWDT_SYNC_LAST);
   assign restart_fire = tick & s_q.rst_pend & (s_q.rst_cnt == `WWDT_SYNC_LAST);
   assign debug_exit = ~debug_halt & s_q.dbg_prev;
   // Counting never depends on sleep state; it needs an oscillator tick outside debug while the watchdog runs
   assign run_tick = tick & ~debug_halt & ~debug_exit & ~cfg_fire
                   & (s_q.phase != wwdt_pkg::WWDT_IDLE) & ~s_q.sys_reset;
   assign guard_open = (s_q.guard_cnt != `WWDT_GUARD_RST);
   // A locked or unkeyed write leaves the control bits alone
   assign ctrl_write_ok = ce & bus_req.wr & (bus_req.addr == `WWDT_OFS_CONTROL)
                        & guard_open & ~s_q.lock;
   assign limit = (s_q.phase == wwdt_pkg::WWDT_CLOSED) ? wwdt_cycles(s_q.run_window)
                                                       : wwdt_cycles(s_q.run_period);
   assign cnt_inc = s_q.cnt + 14'h0001;

   // ************************************************************
   // Next state
   // ************************************************************

   // Watchdog-domain work first so that bus sets below win over clears
   always_comb
   begin
      s_d = s_q;
      if (ce)
      begin
         s_d.wd_prev = wd_osc_clk;
         s_d.dbg_prev = debug_halt;
         s_d.rdata = `WWDT_RDATA_RST;
         if (bus_req.rd)
         begin
            s_d.rdata = wwdt_read(bus_req.addr, s_q);
         end
         // Key window closes on its own after a few cycles
         if (guard_open)
         begin
            s_d.guard_cnt = s_q.guard_cnt - 4'h1;
         end
         // Both synchronisers advance only on oscillator ticks
         if (tick && s_q.sync_pend)
         begin
            s_d.sync_cnt = s_q.sync_cnt + 2'h1;
            if (cfg_fire)
            begin
               s_d.sync_pend = 1'b0;
            end
         end
         if (tick && s_q.rst_pend)
         begin
            s_d.rst_cnt = s_q.rst_cnt + 2'h1;
            if (restart_fire)
            begin
               s_d.rst_pend = 1'b0;
            end
         end
         // A restart is taken only when none is in flight
         if (watchdog_restart_instr && !s_q.rst_pend)
         begin
            s_d.rst_pend = 1'b1;
            s_d.rst_cnt = 2'h0;
         end
         // A finished transfer lands even in debug, so a cleared busy flag never lies
         if (cfg_fire)
         begin
            s_d.run_period = s_q.ctrl[`WWDT_CTRL_PERIOD_LSB +: 4];
            s_d.run_window = s_q.ctrl[`WWDT_CTRL_WINDOW_LSB +: 4];
            s_d.phase = wwdt_start_phase(s_q.ctrl);
         end
         // Counter sequence
         if (debug_halt)
         begin
            s_d.cnt = 14'h0000;
         end
         else if (cfg_fire)
         begin
            s_d.cnt = 14'h0000;
         end
         else if (debug_exit)
         begin
            // Resume with a plain timeout; closed period waits for a restart
            s_d.cnt = 14'h0000;
            if (s_q.phase != wwdt_pkg::WWDT_IDLE && s_q.run_window != `WWDT_CODE_OFF)
            begin
               s_d.phase = wwdt_pkg::WWDT_FIRST;
            end
         end
         else if (run_tick)
         begin
            if (restart_fire)
            begin
               if (s_q.phase == wwdt_pkg::WWDT_CLOSED)
               begin
                  s_d.sys_reset = 1'b1;
               end
               else
               begin
                  s_d.cnt = 14'h0000;
                  s_d.phase = (s_q.run_window != `WWDT_CODE_OFF) ? wwdt_pkg::WWDT_CLOSED
                                                                 : wwdt_pkg::WWDT_OPEN;
               end
            end
            else if (cnt_inc >= limit)
            begin
               if (s_q.phase == wwdt_pkg::WWDT_CLOSED)
               begin
                  s_d.cnt = 14'h0000;
                  s_d.phase = wwdt_pkg::WWDT_OPEN;
               end
               else
               begin
                  s_d.sys_reset = 1'b1;
               end
            end
            else
            begin
               s_d.cnt = cnt_inc;
            end
         end
         // Register writes; a control write while busy is the caller's fault
         if (ctrl_write_ok)
         begin
            s_d.ctrl = bus_req.wdata;
            s_d.sync_pend = 1'b1;
            s_d.sync_cnt = 2'h0;
            s_d.guard_cnt = `WWDT_GUARD_RST;
         end
         if (bus_req.wr && bus_req.addr == `WWDT_OFS_STATUS && guard_open)
         begin
            if (bus_req.wdata[`WWDT_STAT_LOCK_BIT])
            begin
               s_d.lock = 1'b1;
            end
            else if (debug_halt)
            begin
               s_d.lock = 1'b0;
            end
            s_d.guard_cnt = `WWDT_GUARD_RST;
         end
         if (bus_req.wr && bus_req.addr == `WWDT_OFS_GUARD)
         begin
            s_d.guard_cnt = (bus_req.wdata == UNLOCK_KEY) ? GUARD_CYCLES
                                                          : `WWDT_GUARD_RST;
         end
      end
   end

   // ************************************************************
   // State register
   // ************************************************************

   // Reset loads the fuse image; the reset acts even with the enable low
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_q <= '0;
         s_q.ctrl <= wd_fuse_config;
         s_q.run_period <= wd_fuse_config[`WWDT_CTRL_PERIOD_LSB +: 4];
         s_q.run_window <= wd_fuse_config[`WWDT_CTRL_WINDOW_LSB +: 4];
         s_q.lock <= (wd_fuse_config[`WWDT_CTRL_PERIOD_LSB +: 4] != `WWDT_CODE_OFF);
         s_q.phase <= wwdt_start_phase(wd_fuse_config);
         // Seed the edge detector from the pin so that release brings no false tick
         s_q.wd_prev <= wd_osc_clk;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign rdata = s_q.rdata;
   assign wd_sys_reset = s_q.sys_reset;

   // ************************************************************
   // Assertions
   // ************************************************************

   sequence s_ctrl_write;
      ce && bus_req.wr && bus_req.addr == `WWDT_OFS_CONTROL;
   endsequence

   sequence s_restart_taken;
      ce && watchdog_restart_instr && !s_q.rst_pend;
   endsequence

   sequence s_closed_restart;
      run_tick && restart_fire && s_q.phase == wwdt_pkg::WWDT_CLOSED;
   endsequence

   property p_off_idle;
      @(posedge clk) disable iff (rst)
      s_q.run_period == `WWDT_CODE_OFF |-> s_q.phase == wwdt_pkg::WWDT_IDLE;
   endproperty
   a_off_idle: assert property (p_off_idle) else $error("watchdog active with period off");

   property p_lock_blocks;
      @(posedge clk) disable iff (rst)
      s_ctrl_write and (s_q.lock) |=> $stable(s_q.ctrl);
   endproperty
   a_lock_blocks: assert property (p_lock_blocks) else $error("locked control changed");

   property p_no_key;
      @(posedge clk) disable iff (rst)
      s_ctrl_write and (s_q.guard_cnt == 4'h0) |=> $stable(s_q.ctrl) && !$rose(s_q.sync_pend);
   endproperty
   a_no_key: assert property (p_no_key) else $error("control changed without key");

   property p_sync_set;
      @(posedge clk) disable iff (rst)
      ctrl_write_ok |=> s_q.sync_pend && s_q.sync_cnt == 2'h0;
   endproperty
   a_sync_set: assert property (p_sync_set) else $error("busy flag not set by write");

   property p_restart_take;
      @(posedge clk) disable iff (rst)
      s_restart_taken |=> s_q.rst_pend && s_q.rst_cnt == 2'h0;
   endproperty
   a_restart_take: assert property (p_restart_take) else $error("restart not captured");

   property p_restart_ignored;
      @(posedge clk) disable iff (rst)
      ce && s_q.rst_pend && !tick |=> $stable(s_q.rst_cnt) && s_q.rst_pend;
   endproperty
   a_restart_ignored: assert property (p_restart_ignored) else $error("restart restarted sync");

   property p_debug_clear;
      @(posedge clk) disable iff (rst)
      ce && debug_halt |=> s_q.cnt == 14'h0000;
   endproperty
   a_debug_clear: assert property (p_debug_clear) else $error("count not cleared in debug");

   property p_closed_reset;
      @(posedge clk) disable iff (rst)
      s_closed_restart |=> wd_sys_reset;
   endproperty
   a_closed_reset: assert property (p_closed_reset) else $error("closed restart no reset");

   property p_open_timeout;
      @(posedge clk) disable iff (rst)
      run_tick && !restart_fire && s_q.phase == wwdt_pkg::WWDT_OPEN
         && cnt_inc == wwdt_cycles(s_q.run_period) |=> wd_sys_reset;
   endproperty
   a_open_timeout: assert property (p_open_timeout) else $error("open timeout missed");

   property p_reset_sticky;
      @(posedge clk) disable iff (rst)
      wd_sys_reset |=> wd_sys_reset [*2];
   endproperty
   a_reset_sticky: assert property (p_reset_sticky) else $error("reset request dropped");

   property p_lock_holds;
      @(posedge clk) disable iff (rst)
      s_q.lock && !debug_halt |=> s_q.lock;
   endproperty
   a_lock_holds: assert property (p_lock_holds) else $error("lock cleared outside debug");

   property p_fuse_lock;
      @(posedge clk) disable iff (rst)
      $fell(rst) |-> s_q.lock == (s_q.ctrl[3:0] != 4'h0);
   endproperty
   a_fuse_lock: assert property (p_fuse_lock) else $error("fuse lock wrong");

endmodule : wwdt_top

`default_nettype wire

// ===== verif/wwdt_cpu_model.sv
// CPU side model: watchdog oscillator source and restart instruction issuer
`timescale 1ns/10ps
`default_nettype none

module wwdt_cpu_model (
   input wire logic clk,
   input wire logic kick,
   output logic watchdog_restart_instr,
   output logic wd_osc_clk
);
   // ************************************************************
   // Oscillator and restart
   // ************************************************************
   logic [2:0] div_q = 3'h0;
   logic restart_q = 1'b0;

   // Oscillator runs free, eight clocks a period, so long counts stay short
   always @(posedge clk)
   begin
      div_q <= div_q + 3'h1;
      restart_q <= kick;
   end

   // Each kick from the bench becomes one instruction pulse of one cycle
   assign wd_osc_clk = div_q[2];
   assign watchdog_restart_instr = restart_q;
endmodule : wwdt_cpu_model

`default_nettype wire

// ===== verif/wwdt_top_tb.sv
// Self-checking bench for the windowed watchdog
`timescale 1ns/10ps
`include "wwdt_consts.svh"
`default_nettype none

module wwdt_top_tb;
   // ************************************************************
   // Signals and instances
   // ************************************************************
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic kick = 1'b0;
   logic ce = 1'b1;
   logic debug_halt = 1'b0;
   logic [7:0] fuse = 8'h00;
   wwdt_pkg::wwdt_bus_req_t req = '0;
   logic [7:0] rdata;
   logic restart;
   logic osc;
   logic wd_sys_reset;
   logic [7:0] rd_v;
   int n_errors = 0;
   int n_tests = 0;
   int cyc = 0;

   wwdt_top u_dut (
      .clk(clk), .rst(rst), .ce(ce), .bus_req(req), .rdata(rdata),
      .watchdog_restart_instr(restart), .debug_halt(debug_halt), .wd_osc_clk(osc),
      .wd_fuse_config(fuse), .wd_sys_reset(wd_sys_reset)
   );

   wwdt_cpu_model u_cpu (
      .clk(clk), .kick(kick), .watchdog_restart_instr(restart), .wd_osc_clk(osc)
   );

   // Clock and hang guard
   always #20 clk = ~clk;

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         report_and_stop();
      end
   end

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic report_and_stop();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // One write cycle; a following call lets one edge pass first
   task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req <= '0;
   endtask : bus_wr

   // Read data stands only in the cycle after the strobe
   task automatic bus_rd(input logic [7:0] a);
      @(posedge clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req <= '0;
      #1;
      rd_v = rdata;
   endtask : bus_rd

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      bus_rd(a);
      check(rd_v, exp);
   endtask : rd_chk

   task automatic key_wr(input logic [7:0] a, input logic [7:0] d);
      bus_wr(`WWDT_OFS_GUARD, `WWDT_UNLOCK_KEY);
      bus_wr(a, d);
   endtask : key_wr

   // Busy must show at once, then clear within a bounded poll
   task automatic wait_sync();
      // Lock is clear at every call, so the whole status byte is known
      rd_chk(`WWDT_OFS_STATUS, 8'h01);
      for (int i = 0; i < 40 && rd_v[0] !== 1'b0; i++)
         bus_rd(`WWDT_OFS_STATUS);
      check(rd_v, 8'h00);
   endtask : wait_sync

   // Returns once the design has acted on the n-th oscillator edge
   task automatic ticks(input int n);
      repeat (n) @(posedge osc);
      @(posedge clk);
      #1;
   endtask : ticks

   task automatic restart_pulse();
      @(posedge clk);
      kick <= 1'b1;
      @(posedge clk);
      kick <= 1'b0;
   endtask : restart_pulse

   task automatic do_reset(input logic [7:0] f);
      @(posedge clk);
      fuse <= f;
      rst <= 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
   endtask : do_reset

   task automatic quiet();
      check({7'h00, wd_sys_reset}, 8'h00);
   endtask : quiet

   task automatic expect_reset(input int max);
      for (int i = 0; i < max && wd_sys_reset !== 1'b1; i++)
         ticks(1);
      check({7'h00, wd_sys_reset}, 8'h01);
   endtask : expect_reset

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset_vals();
      do_reset(8'h00);
      rd_chk(`WWDT_OFS_STATUS, 8'h00);
      rd_chk(`WWDT_OFS_CONTROL, 8'h00);
      rd_chk(`WWDT_OFS_GUARD, 8'h00);
      bus_wr(8'h3C, 8'hFF);
      rd_chk(8'h3C, 8'h00);
      ticks(30);
      quiet();
   endtask : t_reset_vals

   // Unkeyed write, then a write one cycle too late after the key
   task automatic t_protect();
      bus_wr(`WWDT_OFS_CONTROL, 8'h01);
      bus_wr(`WWDT_OFS_GUARD, `WWDT_UNLOCK_KEY);
      repeat (3) @(posedge clk);
      bus_wr(`WWDT_OFS_CONTROL, 8'h01);
      rd_chk(`WWDT_OFS_CONTROL, 8'h00);
      rd_chk(`WWDT_OFS_STATUS, 8'h00);
   endtask : t_protect

   task automatic t_normal();
      int lim;
      for (int p = 1; p <= 3; p++)
      begin
         lim = 8 << (p - 1);
         do_reset(8'h00);
         key_wr(`WWDT_OFS_CONTROL, 8'(p));
         wait_sync();
         rd_chk(`WWDT_OFS_CONTROL, 8'(p));
         ticks(lim - 1);
         quiet();
         expect_reset(1);
      end
   endtask : t_normal

   // Restarts keep it alive; the last one acts two ticks late
   task automatic t_kick();
      do_reset(8'h00);
      key_wr(`WWDT_OFS_CONTROL, 8'h01);
      wait_sync();
      repeat (6)
      begin
         ticks(5);
         restart_pulse();
      end
      quiet();
      ticks(9);
      quiet();
      expect_reset(1);
   endtask : t_kick

   task automatic t_window();
      do_reset(8'h00);
      key_wr(`WWDT_OFS_CONTROL, 8'h12);
      wait_sync();
      rd_chk(`WWDT_OFS_CONTROL, 8'h12);
      ticks(3);
      restart_pulse();
      restart_pulse();
      ticks(4);
      quiet();
      restart_pulse();
      expect_reset(4);
   endtask : t_window

   task automatic t_open();
      do_reset(8'h00);
      key_wr(`WWDT_OFS_CONTROL, 8'h12);
      wait_sync();
      restart_pulse();
      ticks(12);
      restart_pulse();
      ticks(25);
      quiet();
      expect_reset(1);
   endtask : t_open

   task automatic t_lock_debug();
      do_reset(8'h01);
      rd_chk(`WWDT_OFS_STATUS, 8'h80);
      rd_chk(`WWDT_OFS_CONTROL, 8'h01);
      key_wr(`WWDT_OFS_CONTROL, 8'h00);
      rd_chk(`WWDT_OFS_CONTROL, 8'h01);
      key_wr(`WWDT_OFS_STATUS, 8'h00);
      rd_chk(`WWDT_OFS_STATUS, 8'h80);
      @(posedge clk);
      debug_halt <= 1'b1;
      ticks(20);
      quiet();
      key_wr(`WWDT_OFS_STATUS, 8'h00);
      rd_chk(`WWDT_OFS_STATUS, 8'h00);
      key_wr(`WWDT_OFS_CONTROL, 8'h00);
      wait_sync();
      @(posedge clk);
      debug_halt <= 1'b0;
      ticks(20);
      quiet();
   endtask : t_lock_debug

   // A restart right after debug must not meet a closed period
   task automatic t_debug_window();
      do_reset(8'h00);
      key_wr(`WWDT_OFS_CONTROL, 8'h12);
      wait_sync();
      restart_pulse();
      ticks(4);
      quiet();
      @(posedge clk);
      debug_halt <= 1'b1;
      ticks(3);
      @(posedge clk);
      debug_halt <= 1'b0;
      restart_pulse();
      ticks(6);
      quiet();
      restart_pulse();
      expect_reset(4);
   endtask : t_debug_window

   // Enable low freezes the count, so a frozen watchdog overruns no timeout
   task automatic t_freeze();
      do_reset(8'h01);
      @(posedge clk);
      ce <= 1'b0;
      ticks(12);
      quiet();
      @(posedge clk);
      ce <= 1'b1;
      expect_reset(9);
   endtask : t_freeze

   // Main sequence
   initial
   begin
      t_reset_vals();
      t_protect();
      t_normal();
      t_kick();
      t_window();
      t_open();
      t_lock_debug();
      t_debug_window();
      t_freeze();
      report_and_stop();
   end
endmodule : wwdt_top_tb

`default_nettype wire
